//--- core/eiss_top.sv
// External interrupt pin selection, sensitivity and wake-up with AHB-Lite registers
`timescale 1ns/1ns

// ********
// Notes on behaviour
// ********
// Notes on behaviour
// RQ1: Sense register: two bits per source.
// RQ2: Codes: fall+low, rise, fall, both edges.
// RQ3: Sense writes accepted only while mask set.
// RQ4: Changing a sense field clears its pending.
// RQ5: Pin select resets to 0x0c.
// RQ6: Source 3 from port B lines 0-2.
// RQ7: Source 2 from port B lines 3-6.
// RQ8: Source 1 from port A lines 4-7.
// RQ9: Source 0 from port A lines 0-3.
// RQ10: Source 2 on B4 cannot wake halt.
// RQ11: Halt entry forces interrupt mask clear.
// RQ12: Halt exit waits 256 or 4096 cycles.
// RQ13: Wait clears mask; any request ends it.
// RQ14: Requests taken only with mask clear.
// RQ15: Edge requests latch, clear on service entry.
// RQ16: Source 3 code 11 means no input.
module eiss_top
    import eiss_pkg::*;
#(
    parameter int NPA = 8,
    parameter int NPB = 7
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // Port pins
    input  wire logic [NPA-1:0]   port_a_pins,
    input  wire logic [NPB-1:0]   port_b_pins,
    // Core interrupt interface
    input  wire logic             core_imask,
    input  wire logic [3:0]       svc_ack,
    output logic [3:0]            irq_take,
    output logic                  imask_force_clr,
    // Core power interface
    input  wire logic             halt_instr,
    input  wire logic             wfi_instr,
    input  wire logic             wake_reset_req,
    output logic                  osc_on,
    output logic                  cpu_stall,
    output logic                  resume_irq,
    output logic                  resume_reset,
    // Interrupt to system
    output logic                  irq
);

    // ********
    // Pin synchronisers
    // ********
    logic [NPA-1:0] pa_s1_reg;
    logic [NPA-1:0] pa_s2_reg;
    logic [NPB-1:0] pb_s1_reg;
    logic [NPB-1:0] pb_s2_reg;

    // Idle level is high so that reset does not look like a falling edge
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pa_s1_reg <= '1;
            pa_s2_reg <= '1;
            pb_s1_reg <= '1;
            pb_s2_reg <= '1;
        end else begin
            pa_s1_reg <= port_a_pins;
            pa_s2_reg <= pa_s1_reg;
            pb_s1_reg <= port_b_pins;
            pb_s2_reg <= pb_s1_reg;
        end
    end

    // ********
    // Registers
    // ********
    logic [7:0] sense_reg;
    logic [7:0] pinsel_reg;
    logic [5:0] status_reg;
    logic [5:0] mask_reg;
    logic [0:0] pwrctl_reg;

    logic [1:0] src3_sense_field;
    logic [1:0] src2_sense_field;
    logic [1:0] src1_sense_field;
    logic [1:0] src0_sense_field;
    logic [1:0] src3_pin_field;
    logic [1:0] src2_pin_field;
    logic [1:0] src1_pin_field;
    logic [1:0] src0_pin_field;

    assign src3_sense_field = sense_reg[7:6];           // [RQ1]
    assign src2_sense_field = sense_reg[5:4];           // [RQ1]
    assign src1_sense_field = sense_reg[3:2];           // [RQ1]
    assign src0_sense_field = sense_reg[1:0];           // [RQ1]
    assign src3_pin_field   = pinsel_reg[7:6];
    assign src2_pin_field   = pinsel_reg[5:4];
    assign src1_pin_field   = pinsel_reg[3:2];
    assign src0_pin_field   = pinsel_reg[1:0];

    // ********
    // AHB-Lite address phase capture
    // ********
    logic       dph_wr_reg;
    logic [7:0] dph_addr_reg;
    logic       aph_valid;
    logic [7:0] aph_addr;

    assign aph_valid = hsel && hready && htrans[1];
    assign aph_addr  = {haddr[7:2], 2'h0};

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dph_wr_reg   <= 1'b0;
            dph_addr_reg <= 8'h00;
        end else begin
            dph_wr_reg   <= aph_valid && hwrite;
            dph_addr_reg <= aph_addr;
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    logic wr_sense;
    logic wr_pinsel;
    logic wr_status;
    logic wr_mask;
    logic wr_pwrctl;

    assign wr_sense  = dph_wr_reg && dph_addr_reg == EISS_OFS_SENSE;
    assign wr_pinsel = dph_wr_reg && dph_addr_reg == EISS_OFS_PINSEL;
    assign wr_status = dph_wr_reg && dph_addr_reg == EISS_OFS_STATUS;
    assign wr_mask   = dph_wr_reg && dph_addr_reg == EISS_OFS_MASK;
    assign wr_pwrctl = dph_wr_reg && dph_addr_reg == EISS_OFS_PWRCTL;

    // Writes with the mask clear are dropped silently; bus still says OKAY
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sense_reg <= EISS_SENSE_RST;
        end else if (wr_sense && core_imask) begin
            sense_reg <= hwdata[7:0];                   // [RQ3]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pinsel_reg <= EISS_PINSEL_RST;              // [RQ5]
        end else if (wr_pinsel) begin
            pinsel_reg <= hwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mask_reg   <= EISS_MASK_RST;
            pwrctl_reg <= EISS_PWRCTL_RST;
        end else begin
            if (wr_mask) begin
                mask_reg <= hwdata[5:0];
            end
            if (wr_pwrctl) begin
                pwrctl_reg <= hwdata[0:0];
            end
        end
    end

    // ********
    // Pin routing
    // ********
    logic [3:0] src_pin;
    logic       external_source_3;
    logic       external_source_2;
    logic       external_source_1;
    logic       external_source_0;

    always_comb begin
        case (src3_pin_field)
            2'h0:    external_source_3 = pb_s2_reg[0];  // [RQ6]
            2'h1:    external_source_3 = pb_s2_reg[1];  // [RQ6]
            2'h2:    external_source_3 = pb_s2_reg[2];  // [RQ6]
            default: external_source_3 = 1'b1;          // [RQ16]
        endcase
    end

    always_comb begin
        case (src2_pin_field)
            2'h0:    external_source_2 = pb_s2_reg[3];  // [RQ7]
            2'h1:    external_source_2 = pb_s2_reg[4];  // [RQ7]
            2'h2:    external_source_2 = pb_s2_reg[5];  // [RQ7]
            default: external_source_2 = pb_s2_reg[6];  // [RQ7]
        endcase
    end

    // Source 1 and source 0 pick within their nibble of port A
    always_comb begin
        external_source_1 = pa_s2_reg[{1'b1, src1_pin_field}]; // [RQ8]
        external_source_0 = pa_s2_reg[{1'b0, src0_pin_field}]; // [RQ9]
    end

    assign src_pin = {external_source_3, external_source_2,
                      external_source_1, external_source_0};

    // ********
    // Per-source detection
    // ********
    logic [3:0] pending;
    logic [3:0] request;
    logic [3:0] edge_evt;
    logic [7:0] sense_all;

    assign sense_all = {src3_sense_field, src2_sense_field,
                        src1_sense_field, src0_sense_field};

    genvar g;
    generate
        for (g = 0; g < EISS_NSRC; g++) begin : gen_src
            eiss_src_detect u_det (
                .clk      (clk),
                .reset_n  (reset_n),
                .pin      (src_pin[g]),
                .sense    (sense_all[2*g+1:2*g]),
                .svc_ack  (svc_ack[g]),
                .pending  (pending[g]),
                .request  (request[g]),
                .edge_evt (edge_evt[g])
            );
        end
    endgenerate

    // ********
    // Wake-up sequencing
    // ********
    logic [3:0] halt_src_ok;
    logic       halt_wake_req;
    logic       halt_woke;
    logic       wait_woke;
    logic [3:0] pwr_state;

    // B4 is not a halt wake-up source; it still interrupts when running
    assign halt_src_ok   = {1'b1, src2_pin_field != EISS_SRC2_PB4, 2'h3}; // [RQ10]
    assign halt_wake_req = |(request & halt_src_ok);    // [RQ10] [RQ14]

    eiss_pwr_wake u_pwr (
        .clk             (clk),
        .reset_n         (reset_n),
        .halt_instr      (halt_instr),
        .wfi_instr       (wfi_instr),
        .wake_reset_req  (wake_reset_req),
        .halt_wake_req   (halt_wake_req),
        .any_req         (|request),
        .long_delay      (pwrctl_reg[0]),
        .imask_force_clr (imask_force_clr),
        .osc_on          (osc_on),
        .cpu_stall       (cpu_stall),
        .resume_irq      (resume_irq),
        .resume_reset    (resume_reset),
        .halt_woke       (halt_woke),
        .wait_woke       (wait_woke),
        .state           (pwr_state)
    );

    // Requests reach the core only with the mask clear and the core running or in wait
    assign irq_take = request & {4{~core_imask & ~pwr_state[3] & ~pwr_state[2]}}; // [RQ14]

    // ********
    // Sticky status and interrupt line
    // ********
    logic [5:0] status_set;

    assign status_set = {wait_woke, halt_woke, edge_evt};

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_reg <= EISS_STATUS_RST;
        end else begin
            status_reg <= (status_reg & ~(wr_status ? hwdata[5:0] : 6'h00)) | status_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_reg & mask_reg);
        end
    end

    // ********
    // Read data
    // ********
    logic [31:0] rd_mux;

    always_comb begin
        case (aph_addr)
            EISS_OFS_SENSE:  rd_mux = {24'h000000, sense_reg};
            EISS_OFS_PINSEL: rd_mux = {24'h000000, pinsel_reg};
            EISS_OFS_STATUS: rd_mux = {26'h0000000, status_reg};
            EISS_OFS_MASK:   rd_mux = {26'h0000000, mask_reg};
            EISS_OFS_PWRCTL: rd_mux = {31'h00000000, pwrctl_reg};
            EISS_OFS_STATE:  rd_mux = {20'h00000, pwr_state, request, pending};
            default:         rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
        end else if (aph_valid && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

endmodule

//--- core/eiss_pkg.sv
// Shared constants for the external interrupt select and sense block
package eiss_pkg;

    // ********
    // Register byte offsets
    // ********
    localparam logic [7:0] EISS_OFS_SENSE  = 8'h00;
    localparam logic [7:0] EISS_OFS_PINSEL = 8'h04;
    localparam logic [7:0] EISS_OFS_STATUS = 8'h08;
    localparam logic [7:0] EISS_OFS_MASK   = 8'h0c;
    localparam logic [7:0] EISS_OFS_PWRCTL = 8'h10;
    localparam logic [7:0] EISS_OFS_STATE  = 8'h14;

    // ********
    // Reset values
    // ********
    localparam logic [7:0] EISS_SENSE_RST  = 8'h00;
    localparam logic [7:0] EISS_PINSEL_RST = 8'h0c;
    localparam logic [5:0] EISS_STATUS_RST = 6'h00;
    localparam logic [5:0] EISS_MASK_RST   = 6'h00;
    localparam logic [0:0] EISS_PWRCTL_RST = 1'h0;

    // ********
    // Field positions and codes
    // ********
    localparam int EISS_NSRC          = 4;
    localparam int EISS_ST_HALT_WAKE  = 4;
    localparam int EISS_ST_WAIT_WAKE  = 5;
    localparam logic [1:0] EISS_SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] EISS_SENSE_RISE     = 2'h1;
    localparam logic [1:0] EISS_SENSE_FALL     = 2'h2;
    localparam logic [1:0] EISS_SENSE_BOTH     = 2'h3;
    localparam logic [1:0] EISS_SRC2_PB4       = 2'h1;
    localparam logic [1:0] EISS_SRC3_NONE      = 2'h3;

    // ********
    // Oscillator start-up counts in CPU cycles
    // ********
    localparam logic [12:0] EISS_START_SHORT = 13'h0100;
    localparam logic [12:0] EISS_START_LONG  = 13'h1000;

    typedef enum logic [3:0] {
        EISS_RUN   = 4'h1,
        EISS_WAIT  = 4'h2,
        EISS_HALT  = 4'h4,
        EISS_START = 4'h8
    } eiss_pwr_t;

endpackage

//--- core/eiss_src_detect.sv
// One external source: edge or level detection and pending latch
`timescale 1ns/1ns
module eiss_src_detect
    import eiss_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Source input and control
    input  wire logic       pin,
    input  wire logic [1:0] sense,
    input  wire logic       svc_ack,
    // Results
    output logic            pending,
    output logic            request,
    output logic            edge_evt
);
    logic       pin_prev_reg;
    logic [1:0] sense_prev_reg;
    logic       pending_reg;
    logic       rise;
    logic       fall;
    logic       sense_chg;

    assign rise      = pin & ~pin_prev_reg;
    assign fall      = ~pin & pin_prev_reg;
    assign sense_chg = sense != sense_prev_reg;

    always_comb begin
        case (sense)
            EISS_SENSE_FALL_LOW: edge_evt = fall;       // [RQ2]
            EISS_SENSE_RISE:     edge_evt = rise;       // [RQ2]
            EISS_SENSE_FALL:     edge_evt = fall;       // [RQ2]
            default:             edge_evt = rise | fall; // [RQ2]
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_prev_reg   <= 1'b1;
            sense_prev_reg <= EISS_SENSE_RST[1:0];
        end else begin
            pin_prev_reg   <= pin;
            sense_prev_reg <= sense;
        end
    end

    // New edge beats an acknowledge; a sense change discards it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pending_reg <= 1'b0;
        end else if (sense_chg) begin
            pending_reg <= 1'b0;                        // [RQ4]
        end else if (edge_evt) begin
            pending_reg <= 1'b1;                        // [RQ15]
        end else if (svc_ack) begin
            pending_reg <= 1'b0;                        // [RQ15]
        end
    end

    assign pending = pending_reg;
    // Low level keeps requesting in the fall-and-low mode
    assign request = pending_reg | (sense == EISS_SENSE_FALL_LOW && !pin && !sense_chg); // [RQ2]
endmodule

//--- core/eiss_pwr_wake.sv
// Wait, halt and oscillator start-up sequencing for interrupt wake-up
`timescale 1ns/1ns
module eiss_pwr_wake
    import eiss_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Core events
    input  wire logic halt_instr,
    input  wire logic wfi_instr,
    input  wire logic wake_reset_req,
    input  wire logic halt_wake_req,
    input  wire logic any_req,
    input  wire logic long_delay,
    // Results
    output logic      imask_force_clr,
    output logic      osc_on,
    output logic      cpu_stall,
    output logic      resume_irq,
    output logic      resume_reset,
    output logic      halt_woke,
    output logic      wait_woke,
    output logic [3:0] state
);
    eiss_pwr_t   st_reg;
    logic [12:0] cnt_reg;
    logic        by_reset_reg;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_reg       <= EISS_RUN;
            cnt_reg      <= 13'h0000;
            by_reset_reg <= 1'b0;
        end else begin
            case (st_reg)
                EISS_RUN: begin
                    if (halt_instr) begin
                        st_reg <= EISS_HALT;
                    end else if (wfi_instr) begin
                        st_reg <= EISS_WAIT;
                    end
                end
                EISS_WAIT: begin
                    if (any_req || wake_reset_req) begin
                        st_reg <= EISS_RUN;             // [RQ13]
                    end
                end
                EISS_HALT: begin
                    if (halt_wake_req || wake_reset_req) begin
                        st_reg       <= EISS_START;     // [RQ12]
                        by_reset_reg <= wake_reset_req;
                        cnt_reg      <= long_delay ? EISS_START_LONG : EISS_START_SHORT;
                    end
                end
                EISS_START: begin
                    if (cnt_reg == 13'h0001) begin
                        st_reg <= EISS_RUN;             // [RQ12]
                    end
                    cnt_reg <= cnt_reg - 13'h0001;
                end
                default: st_reg <= EISS_RUN;
            endcase
        end
    end

    // Mask held clear on halt entry and throughout the wait
    assign imask_force_clr = (st_reg == EISS_RUN && halt_instr)
                           || st_reg == EISS_WAIT || st_reg == EISS_HALT; // [RQ11] [RQ13]
    assign osc_on       = st_reg != EISS_HALT;
    assign cpu_stall    = st_reg != EISS_RUN;
    assign resume_irq   = st_reg == EISS_START && cnt_reg == 13'h0001 && !by_reset_reg;
    assign resume_reset = st_reg == EISS_START && cnt_reg == 13'h0001 && by_reset_reg;
    assign halt_woke    = st_reg == EISS_HALT && (halt_wake_req || wake_reset_req);
    assign wait_woke    = st_reg == EISS_WAIT && (any_req || wake_reset_req);
    assign state        = st_reg;
endmodule

//--- bench/eiss_top_properties.sv
// Concurrent checks on the ports of the interrupt select and sense block
`timescale 1ns/1ns
module eiss_top_properties
    import eiss_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Bus and core ports
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       core_imask,
    input wire logic [3:0] irq_take,
    input wire logic       imask_force_clr,
    input wire logic       halt_instr,
    input wire logic       wfi_instr,
    input wire logic       osc_on,
    input wire logic       cpu_stall,
    input wire logic       resume_irq,
    input wire logic       resume_reset
);
    // ********
    // Start-up cycle counter
    // ********
    logic        halt_seen_reg;
    logic [12:0] start_cnt_reg;
    always_ff @(posedge clk) begin
        if (!reset_n || resume_irq || resume_reset) begin
            halt_seen_reg <= 1'b0;
        end else if (!osc_on) begin
            halt_seen_reg <= 1'b1;
        end
    end
    // Zero in the first start-up cycle, so it reads N-1 in the last one
    always_ff @(posedge clk) begin
        start_cnt_reg <= (reset_n && halt_seen_reg && osc_on) ? start_cnt_reg + 13'h1 : 13'h0;
    end
    // ********
    // Properties
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_bus_okay;
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
    property p_take_mask;
        (irq_take != 4'h0) |-> !core_imask;
    endproperty
    a_take_mask: assert property (p_take_mask) else $error("request offered while masked");
    property p_halt_entry;
        halt_instr && !cpu_stall |-> imask_force_clr ##1 !osc_on;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt entry wrong");
    property p_halt_hold;
        !osc_on |-> imask_force_clr && cpu_stall && (irq_take == 4'h0);
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt state outputs wrong");
    property p_wfi_entry;
        wfi_instr && !halt_instr && !cpu_stall |=> cpu_stall && osc_on && imask_force_clr;
    endproperty
    a_wfi_entry: assert property (p_wfi_entry) else $error("wait entry wrong");
    property p_wait_exit;
        imask_force_clr && cpu_stall && osc_on && (irq_take != 4'h0) |=> !cpu_stall;
    endproperty
    a_wait_exit: assert property (p_wait_exit) else $error("wait not ended by request");
    property p_start_stall;
        $rose(osc_on) |-> (cpu_stall && !resume_irq && !resume_reset) [*8];
    endproperty
    a_start_stall: assert property (p_start_stall) else $error("start-up cut short");
    property p_resume_count;
        resume_irq || resume_reset |-> halt_seen_reg &&
            (start_cnt_reg == EISS_START_SHORT - 13'h1 || start_cnt_reg == EISS_START_LONG - 13'h1);
    endproperty
    a_resume_count: assert property (p_resume_count) else $error("start-up length wrong");
    property p_resume_pulse;
        resume_irq || resume_reset |=> !resume_irq && !resume_reset && !cpu_stall;
    endproperty
    a_resume_pulse: assert property (p_resume_pulse) else $error("resume not a pulse");
endmodule

bind eiss_top eiss_top_properties eiss_top_properties_inst (.clk, .reset_n, .hreadyout,
    .hresp, .core_imask, .irq_take, .imask_force_clr, .halt_instr, .wfi_instr, .osc_on,
    .cpu_stall, .resume_irq, .resume_reset);

//--- bench/eiss_core_model.sv
// Behavioural model of the core's interrupt mask and service entry
`timescale 1ns/1ns
module eiss_core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // From the block
    input  wire logic [3:0] irq_take,
    input  wire logic       imask_force_clr,
    // Software mask control
    input  wire logic       sw_set,
    input  wire logic       sw_clr,
    // To the block
    output logic            core_imask,
    output logic [3:0]      svc_ack
);
    // Masked after reset, as the core starts with interrupts disabled
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            core_imask <= 1'b1;
            svc_ack    <= 4'h0;
        end else begin
            svc_ack <= 4'h0;
            if (imask_force_clr) begin
                core_imask <= 1'b0;
            end else if (irq_take != 4'h0 && !core_imask) begin
                // Lowest source wins; entering service sets the mask again
                core_imask <= 1'b1;
                svc_ack    <= irq_take & (~irq_take + 4'h1);
            end else if (sw_set) begin
                core_imask <= 1'b1;
            end else if (sw_clr) begin
                core_imask <= 1'b0;
            end
        end
    end
endmodule

//--- bench/eiss_top_test.sv
// Self-checking testbench for the interrupt select and sense block
`timescale 1ns/1ns
module eiss_top_test
    import eiss_pkg::*;
;
    logic        clk, reset_n, hsel, hwrite, hreadyout, hresp, core_imask, imask_force_clr;
    logic        halt_instr, wfi_instr, wake_reset_req, osc_on, cpu_stall, resume_irq;
    logic        resume_reset, irq, sw_set, sw_clr;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [3:0]  irq_take, svc_ack;
    logic [14:0] pins;
    int          failures, check_count, cyc, p, n;

    eiss_top eiss_top_inst (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .port_a_pins(pins[7:0]),
        .port_b_pins(pins[14:8]), .core_imask, .svc_ack, .irq_take, .imask_force_clr,
        .halt_instr, .wfi_instr, .wake_reset_req, .osc_on, .cpu_stall, .resume_irq,
        .resume_reset, .irq);
    eiss_core_model eiss_core_model_inst (.clk, .reset_n, .irq_take, .imask_force_clr,
        .sw_set, .sw_clr, .core_imask, .svc_ack);

    // ********
    // Clock, timeout and tasks
    // ********
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (failures == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Read data is taken at the edge that ends the data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic pin(input int i, input logic v);
        @(posedge clk) pins[i] <= v;
        repeat (4) @(posedge clk);
    endtask
    task automatic core_mask(input logic v);
        @(posedge clk) {sw_set, sw_clr} <= {v, !v};
        @(posedge clk) {sw_set, sw_clr} <= 2'h0;
        repeat (3) @(posedge clk);
    endtask
    // Halt, wake by pin i (or by reset request), count start-up cycles
    task automatic halt_wake(input int i, input int n_exp, input logic rst);
        @(posedge clk) halt_instr <= 1'b1;
        @(posedge clk) halt_instr <= 1'b0;
        chk(imask_force_clr, 1'b1);
        repeat (3) @(posedge clk);
        chk(osc_on, 1'b0);
        chk(core_imask, 1'b0);
        pins[i] <= 1'b0;
        if (rst) begin
            repeat (20) @(posedge clk);
            chk(osc_on, 1'b0);
            wake_reset_req <= 1'b1;
            @(posedge clk) wake_reset_req <= 1'b0;
        end
        n = 0;
        do begin
            @(posedge clk);
            if (osc_on === 1'b1 && cpu_stall === 1'b1) n++;
        end while (resume_irq !== 1'b1 && resume_reset !== 1'b1);
        chk(n, n_exp);
        chk(resume_reset, rst);
        pin(i, 1'b1);
    endtask

    // ********
    // Main sequence
    // ********
    initial begin
        {reset_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {halt_instr, wfi_instr, wake_reset_req, sw_set, sw_clr} = '0;
        pins = 15'h7fff;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        hsel <= 1'b1;
        xfer(0, EISS_OFS_SENSE, 0); chk(r, 32'h0);
        xfer(0, EISS_OFS_PINSEL, 0); chk(r, 32'h0c);
        xfer(0, 8'h20, 0); chk(r, 32'h0);
        // Sense writes need the core mask set
        core_mask(1'b0);
        xfer(1, EISS_OFS_SENSE, 32'h55);
        xfer(0, EISS_OFS_SENSE, 0); chk(r, 32'h0);
        core_mask(1'b1);
        xfer(1, EISS_OFS_SENSE, 32'hff);
        xfer(0, EISS_OFS_SENSE, 0); chk(r, 32'hff);
        // Every pin code of every source; src3 code 3 drives its code 0 pin, B0
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 4; c++) begin
                p = (s == 0) ? c : (s == 1) ? 4 + c : (s == 2) ? 11 + c : 8 + c % 3;
                xfer(1, EISS_OFS_PINSEL, (32'h0c & ~(32'h3 << (2 * s))) | (c << (2 * s)));
                xfer(1, EISS_OFS_STATUS, 32'h3f);
                pin(p, 1'b0);
                xfer(0, EISS_OFS_STATUS, 0);
                chk(r & 32'hf, (s == 3 && c == 3) ? 0 : 1 << s);
                pin(p, 1'b1);
            end
        end
        xfer(1, EISS_OFS_PINSEL, 32'h0c);
        // Each sense code on source 0; a new code drops the pending request
        for (int k = 0; k < 4; k++) begin
            xfer(1, EISS_OFS_SENSE, k);
            xfer(0, EISS_OFS_STATE, 0); chk(r & 32'h1, 0);
            xfer(1, EISS_OFS_STATUS, 32'h3f);
            pin(0, 1'b0);
            xfer(0, EISS_OFS_STATUS, 0); chk(r & 32'h1, k != 1);
            xfer(1, EISS_OFS_STATUS, 32'h3f);
            pin(0, 1'b1);
            xfer(0, EISS_OFS_STATUS, 0); chk(r & 32'h1, k % 2);
        end
        chk(irq, 1'b0);
        xfer(1, EISS_OFS_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        xfer(1, EISS_OFS_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        // Unmasking lets the core take and acknowledge the request
        core_mask(1'b0);
        xfer(0, EISS_OFS_STATE, 0); chk(r & 32'h1, 0);
        chk(core_imask, 1'b1);
        xfer(1, EISS_OFS_SENSE, 32'h2a);
        xfer(1, EISS_OFS_PINSEL, 32'h1c);
        halt_wake(0, 256, 1'b0);
        xfer(1, EISS_OFS_PWRCTL, 32'h1);
        halt_wake(12, 4096, 1'b1);
        // Wait mode ends on a source 1 falling edge
        @(posedge clk) wfi_instr <= 1'b1;
        @(posedge clk) wfi_instr <= 1'b0;
        repeat (2) @(posedge clk);
        chk(cpu_stall, 1'b1);
        chk(core_imask, 1'b0);
        pins[7] <= 1'b0;
        repeat (8) @(posedge clk);
        chk(cpu_stall, 1'b0);
        finish_test();
    end
endmodule
